// ==== src/wbc_cache_ctrl.v ====
// The implementer's own choices: the address-and-strobe port.
`timescale 1ns/1ns
`include "wbc_defines.vh"
// Function
// R01: copy-back and write-back buffers, four doublewords
// R02: copy-back on replace, write-back on snoop
// R03: victim stays modified, copy to buffer
// R04: fill: writeback_select 1 exclusive, 0 shared
// R05: page_write_through forces shared state
// R06: exclusive write goes modified, no bus
// R07: shared write goes to bus, stays shared
// R08: modified write stays modified, no bus
// R09: software flushes after attribute change
// R10: snoop starts on external_address_strobe
// R11: snoop only during hold state
// R12: sample invalidate_qualifier with strobe
// R13: compare cache and copy-back buffer
// R14: hit_modified two clocks after strobe; code asserts it five clocks after
// R15: system holds hold one clock more
// R16: snoop parallel with processor access; code starts no processor access, even a hit, during hold or a snoop
// R17: read: strobe low, write low, sample select
// R18: burst_last on final fill transfer
// R19: write: strobe low, write high
// R20: system withholds ready until hit seen
// R21: system derives strobe and qualifier
// R22: each master own hold pair
// R23: two state bits per line
// R24: write back before other master completes
// R25: snoop write-back burst four words, offset 0
// R26: after snoop: shared if 0, invalid if 1
module wbc_cache_ctrl (
  input wire CORE_CLK,
  input wire RESET_N,
  input wire CPU_REQ,
  input wire CPU_WR,
  input wire [31:0] CPU_ADDR,
  input wire [31:0] CPU_WDATA,
  input wire PAGE_WRITE_THROUGH,
  input wire FLUSH,
  output wire CPU_ACK,
  output reg [31:0] CPU_RDATA,
  input wire [31:0] ADDR_IN,
  output reg [31:0] ADDR_OUT,
  output reg ADDR_OE,
  input wire [31:0] DATA_IN,
  output reg [31:0] DATA_OUT,
  output reg DATA_OE,
  output reg ADDRESS_STROBE_N,
  output reg WRITE_READ,
  output reg BURST_LAST_N,
  input wire BURST_READY_N,
  input wire WRITEBACK_SELECT,
  input wire HOLD,
  output reg BUS_HOLD_ACKNOWLEDGE,
  input wire BUS_BACKOFF_N,
  input wire ADDRESS_HOLD,
  input wire EXTERNAL_ADDRESS_STROBE_N,
  input wire INVALIDATE_QUALIFIER,
  output reg HIT_MODIFIED_N
);
  // ************************************************
  // input synchronisers
  // ************************************************
  reg [6:0] s1_r;
  reg [6:0] s2_r;
  reg [31:0] da1_r;
  reg [31:0] da2_r;
  reg [31:0] ad1_r;
  reg [31:0] ad2_r;
  always @(posedge CORE_CLK) begin
    s1_r <= {WRITEBACK_SELECT, BURST_READY_N, HOLD, BUS_BACKOFF_N, ADDRESS_HOLD,
      EXTERNAL_ADDRESS_STROBE_N, INVALIDATE_QUALIFIER};
    s2_r <= s1_r;
    da1_r <= DATA_IN;
    da2_r <= da1_r;
    ad1_r <= ADDR_IN;
    ad2_r <= ad1_r;
  end
  wire wbs = s2_r[6];
  wire burst_ready = !s2_r[5];
  wire hold = s2_r[4];
  wire bus_backoff = !s2_r[3];
  wire address_hold = s2_r[2];
  wire external_address_strobe = !s2_r[1];
  wire invalidate_qualifier = s2_r[0];
  // ************************************************
  // cache arrays
  // ************************************************
  reg [1:0] state_r [0:`WBC_NLINES-1];
  reg [`WBC_TAG_W-1:0] tag_r [0:`WBC_NLINES-1];
  reg [127:0] data_r [0:`WBC_NLINES-1];
  wire [3:0] idx = CPU_ADDR[7:4];
  wire [23:0] ctag = CPU_ADDR[31:8];
  wire [1:0] cst = state_r[idx];
  wire chit = (cst != `WBC_ST_INV) && (tag_r[idx] == ctag);
  wire [3:0] sidx = ad2_r[7:4];
  wire [1:0] sst = state_r[sidx];
  wire shit = (sst != `WBC_ST_INV) && (tag_r[sidx] == ad2_r[31:8]);
  // ************************************************
  // buffers
  // ************************************************
  reg cb_load;
  reg cb_take;
  wire wb_load;
  reg wb_take;
  reg [1:0] beat_r;
  wire [1:0] word_sel;
  wire cb_full;
  wire wb_full;
  wire [27:0] cb_addr;
  wire [27:0] wb_addr;
  wire [31:0] cb_word;
  wire [31:0] wb_word;
  wbc_line_buf u_copy_back ( // see R01
    .CORE_CLK(CORE_CLK),
    .RESET_N(RESET_N),
    .load(cb_load),
    .load_data(data_r[idx]),
    .load_addr({tag_r[idx], idx}),
    .take(cb_take),
    .word_sel(word_sel),
    .full_r(cb_full),
    .addr_r(cb_addr),
    .word(cb_word)
  );
  wbc_line_buf u_write_back ( // see R01
    .CORE_CLK(CORE_CLK),
    .RESET_N(RESET_N),
    .load(wb_load),
    .load_data(data_r[sidx]),
    .load_addr(ad2_r[31:4]),
    .take(wb_take),
    .word_sel(word_sel),
    .full_r(wb_full),
    .addr_r(wb_addr),
    .word(wb_word)
  );
  // see R13: copy-back buffer also snooped
  wire cbhit = cb_full && (cb_addr == ad2_r[31:4]);
  wire in_hold = (hold && BUS_HOLD_ACKNOWLEDGE) || bus_backoff || address_hold;
  // ************************************************
  // snoop pipeline
  // ************************************************
  reg snp_v_r;
  reg snp_inv_r;
  reg snp_mod_r;
  reg snp_wait_r;
  wire snp_take = external_address_strobe && in_hold && !snp_v_r && !snp_wait_r; // see R10 R11
  // ************************************************
  // bus state machine
  // ************************************************
  localparam S_IDLE = 6'h01;
  localparam S_FILL = 6'h02;
  localparam S_WRT = 6'h04;
  localparam S_CB = 6'h08;
  localparam S_WB = 6'h10;
  localparam S_DONE = 6'h20;
  reg [5:0] st_r;
  reg [5:0] st_nxt;
  reg wbs_r;
  reg [127:0] fill_r;
  reg ack_r;
  integer i;
  wire last = (beat_r == 2'h3) && burst_ready;
  assign CPU_ACK = ack_r;
  // ************************************************
  // buffer word select
  // ************************************************
  // data must lead the next beat
  wire [1:0] beat_inc = beat_r + 2'h1;
  assign word_sel = (st_r == S_IDLE) ? 2'h0 : beat_inc; // see R25
  always @* begin
    st_nxt = st_r;
    cb_load = 1'b0;
    cb_take = 1'b0;
    wb_take = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (wb_full && !hold && !bus_backoff && !address_hold) begin
          st_nxt = S_WB; // see R24 R16
        end else if (cb_full && !in_hold) begin
          st_nxt = S_CB;
        end else if (CPU_REQ && !ack_r && !in_hold && !snp_v_r) begin
          if (CPU_WR && chit && cst != `WBC_ST_SHR) begin
            st_nxt = S_DONE; // see R06 R08
          end else if (CPU_WR) begin
            st_nxt = S_WRT; // see R07
          end else if (chit) begin
            st_nxt = S_DONE;
          end else begin
            cb_load = (cst == `WBC_ST_MOD) && !cb_full; // see R02 R03
            st_nxt = (cst == `WBC_ST_MOD && cb_full) ? S_IDLE : S_FILL;
          end
        end
      end
      S_FILL: if (last) st_nxt = S_DONE;
      S_WRT: if (burst_ready) st_nxt = S_DONE;
      S_CB: if (last) begin
        st_nxt = S_IDLE;
        cb_take = 1'b1;
      end
      S_WB: if (last) begin
        st_nxt = S_IDLE;
        wb_take = 1'b1;
      end
      S_DONE: st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end
  always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      st_r <= S_IDLE;
      beat_r <= 2'h0;
      ack_r <= 1'b0;
      wbs_r <= 1'b0;
      ADDRESS_STROBE_N <= 1'b1;
      WRITE_READ <= 1'b0;
      BURST_LAST_N <= 1'b1;
      ADDR_OUT <= 32'h0000_0000;
      ADDR_OE <= 1'b0;
      DATA_OUT <= 32'h0000_0000;
      DATA_OE <= 1'b0;
      CPU_RDATA <= 32'h0000_0000;
      BUS_HOLD_ACKNOWLEDGE <= 1'b0;
      fill_r <= 128'h0;
    end else begin
      st_r <= st_nxt;
      ack_r <= (st_nxt == S_DONE);
      ADDRESS_STROBE_N <= !(st_r == S_IDLE && st_nxt != S_IDLE && st_nxt != S_DONE);
      BUS_HOLD_ACKNOWLEDGE <= hold && st_r == S_IDLE && st_nxt == S_IDLE;
      if (st_r == S_IDLE) begin
        beat_r <= 2'h0; // see R25
        case (st_nxt)
          S_FILL: begin
            WRITE_READ <= 1'b0; // see R17
            ADDR_OUT <= {CPU_ADDR[31:4], 4'h0};
          end
          S_WRT: begin
            WRITE_READ <= 1'b1; // see R19
            ADDR_OUT <= CPU_ADDR;
            DATA_OUT <= CPU_WDATA;
          end
          S_CB: begin
            WRITE_READ <= 1'b1;
            ADDR_OUT <= {cb_addr, 4'h0};
            DATA_OUT <= cb_word;
          end
          S_WB: begin
            WRITE_READ <= 1'b1; // see R25
            ADDR_OUT <= {wb_addr, 4'h0};
            DATA_OUT <= wb_word;
          end
          default: WRITE_READ <= WRITE_READ;
        endcase
        ADDR_OE <= st_nxt != S_IDLE && st_nxt != S_DONE;
        DATA_OE <= st_nxt == S_WRT || st_nxt == S_CB || st_nxt == S_WB;
        BURST_LAST_N <= !(st_nxt == S_WRT);
        if (st_nxt == S_DONE && !CPU_WR) begin
          CPU_RDATA <= data_r[idx][32*CPU_ADDR[3:2] +: 32];
        end
      end else if (burst_ready) begin
        beat_r <= beat_r + 2'h1;
        if (st_r == S_FILL) begin
          fill_r[32*beat_r +: 32] <= da2_r;
          if (beat_r == 2'h0) begin
            wbs_r <= wbs; // see R17
          end
          if (beat_r == CPU_ADDR[3:2]) begin
            CPU_RDATA <= da2_r;
          end
        end
        if (st_r == S_CB) begin
          DATA_OUT <= cb_word;
        end
        if (st_r == S_WB) begin
          DATA_OUT <= wb_word;
        end
        BURST_LAST_N <= !(beat_r == 2'h2 || st_r == S_WRT); // see R18
        if (last || st_r == S_WRT) begin
          ADDR_OE <= 1'b0;
          DATA_OE <= 1'b0;
          BURST_LAST_N <= 1'b1;
        end
      end
    end
  end
  // ************************************************
  // line state and data update
  // ************************************************
  wire fill_done = st_r == S_FILL && last;
  wire [1:0] fill_st = (PAGE_WRITE_THROUGH || !(beat_r == 2'h0 ? wbs : wbs_r)) ?
    `WBC_ST_SHR : `WBC_ST_EXC; // see R04 R05
  always @(posedge CORE_CLK) begin
    if (!RESET_N || FLUSH) begin
      for (i = 0; i < `WBC_NLINES; i = i + 1) begin
        state_r[i] <= `WBC_ST_INV;
      end
    end else begin
      if (fill_done) begin
        state_r[idx] <= fill_st; // see R23
        tag_r[idx] <= ctag;
        data_r[idx] <= {da2_r, fill_r[95:0]};
      end else if (st_r == S_IDLE && st_nxt == S_DONE && CPU_WR) begin
        data_r[idx][32*CPU_ADDR[3:2] +: 32] <= CPU_WDATA;
        if (cst == `WBC_ST_EXC) begin
          state_r[idx] <= `WBC_ST_MOD; // see R06
        end
      end else if (st_r == S_WRT && burst_ready && chit) begin
        data_r[idx][32*CPU_ADDR[3:2] +: 32] <= CPU_WDATA; // see R07
      end
      if (snp_v_r && shit) begin
        state_r[sidx] <= snp_inv_r ? `WBC_ST_INV : `WBC_ST_SHR; // see R26
      end
    end
  end
  // ************************************************
  // snoop timing: hit_modified at strobe plus five
  // ************************************************
  assign wb_load = snp_v_r && shit && sst == `WBC_ST_MOD; // see R02
  always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      snp_v_r <= 1'b0;
      snp_inv_r <= 1'b0;
      snp_mod_r <= 1'b0;
      snp_wait_r <= 1'b0;
      HIT_MODIFIED_N <= 1'b1;
    end else begin
      snp_v_r <= snp_take;
      if (snp_take) begin
        snp_inv_r <= invalidate_qualifier; // see R12
      end
      snp_mod_r <= snp_v_r && ((shit && sst == `WBC_ST_MOD) || cbhit); // see R13
      if (snp_mod_r) begin
        HIT_MODIFIED_N <= 1'b0; // see R14
        snp_wait_r <= 1'b1;
      end else if (snp_wait_r && !wb_full && !(cbhit && cb_full) && st_r == S_IDLE) begin
        HIT_MODIFIED_N <= 1'b1;
        snp_wait_r <= 1'b0;
      end
    end
  end
endmodule // wbc_cache_ctrl

// ==== src/wbc_defines.vh ====
`ifndef WBC_DEFINES_VH
`define WBC_DEFINES_VH
// ************************************************
// line states and geometry
// ************************************************
`define WBC_ST_INV 2'h0
`define WBC_ST_EXC 2'h1
`define WBC_ST_MOD 2'h2
`define WBC_ST_SHR 2'h3
`define WBC_LINE_WORDS 4
`define WBC_NLINES 16
`define WBC_IDX_W 4
`define WBC_TAG_W 24
`define WBC_HIT_MODIFIED_DELAY 2
`endif

// ==== src/wbc_line_buf.v ====
`timescale 1ns/1ns
// ************************************************
// four doubleword line buffer
// ************************************************
module wbc_line_buf (
  input wire CORE_CLK,
  input wire RESET_N,
  input wire load,
  input wire [127:0] load_data,
  input wire [27:0] load_addr,
  input wire take,
  input wire [1:0] word_sel,
  output reg full_r,
  output reg [27:0] addr_r,
  output wire [31:0] word
);
  reg [31:0] mem_r [0:3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_w
      always @(posedge CORE_CLK) begin
        if (load) begin
          mem_r[g] <= load_data[32*g+31:32*g];
        end
      end
    end
  endgenerate
  assign word = mem_r[word_sel];
  always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      full_r <= 1'b0;
      addr_r <= 28'h000_0000;
    end else if (load) begin
      full_r <= 1'b1;
      addr_r <= load_addr;
    end else if (take) begin
      full_r <= 1'b0;
    end
  end
endmodule // wbc_line_buf

// ==== testbench/wbc_properties.sv ====
`timescale 1ns/1ns
// ************************************************
// snoop and bus cycle checks
// ************************************************
module wbc_checker (
  input wire CORE_CLK,
  input wire RESET_N,
  input wire EXTERNAL_ADDRESS_STROBE_N,
  input wire HIT_MODIFIED_N,
  input wire ADDRESS_STROBE_N,
  input wire WRITE_READ,
  input wire [31:0] ADDR_OUT,
  input wire ADDR_OE,
  input wire DATA_OE,
  input wire CPU_ACK,
  input wire BUS_HOLD_ACKNOWLEDGE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  a_hit_modified_delay: assert property ($fell(HIT_MODIFIED_N)
    |-> $past(EXTERNAL_ADDRESS_STROBE_N, 5) == 1'b0) else $error("hit flag timing");
  a_hit_modified_stays: assert property ($fell(HIT_MODIFIED_N)
    |=> !HIT_MODIFIED_N [*2]) else $error("hit flag too short");
  a_wb_burst_base: assert property (!HIT_MODIFIED_N && !ADDRESS_STROBE_N
    |-> WRITE_READ && ADDR_OUT[3:0] == 4'h0) else $error("write-back start");
  a_strobe_pulse: assert property (!ADDRESS_STROBE_N
    |=> ADDRESS_STROBE_N) else $error("strobe too long");
  a_strobe_no_hold: assert property (BUS_HOLD_ACKNOWLEDGE
    |-> ADDRESS_STROBE_N) else $error("cycle during hold");
  a_strobe_drives: assert property (!ADDRESS_STROBE_N
    |-> ADDR_OE) else $error("address not driven");
  a_data_on_write: assert property (DATA_OE
    |-> WRITE_READ) else $error("data driven on read");
  a_ack_pulse: assert property (CPU_ACK
    |=> !CPU_ACK) else $error("ack too long");
endmodule // wbc_checker

// ==== testbench/wbc_mem_model.sv ====
`timescale 1ns/1ns
// ************************************************
// burst memory on the far side
// ************************************************
module wbc_mem_model #(
  parameter GAP = 3
) (
  input wire CORE_CLK,
  input wire RESET_N,
  input wire ADDRESS_STROBE_N,
  input wire WRITE_READ,
  input wire BURST_LAST_N,
  input wire [31:0] ADDR_OUT,
  input wire [31:0] DATA_OUT,
  output reg BURST_READY_N = 1'b1,
  output reg [31:0] DATA_IN = 32'h0000_0000,
  output reg [7:0] writes = 8'h00
);
  reg [31:0] mem [0:255];
  reg busy;
  reg wr;
  reg [9:0] adr;
  reg [1:0] beat;
  reg [3:0] dly;
  integer i;
  wire [7:0] idx = {adr[9:4], adr[3:2] + beat};
  initial for (i = 0; i < 256; i = i + 1) mem[i] = 32'hcafe_0000 + i;
  always @(posedge CORE_CLK) begin
    BURST_READY_N <= 1'b1;
    DATA_IN <= ~DATA_IN; // released bus toggles
    if (!RESET_N) begin
      busy <= 1'b0;
      writes <= 8'h00;
    end else if (!busy) begin
      busy <= !ADDRESS_STROBE_N;
      wr <= WRITE_READ;
      adr <= ADDR_OUT[9:0];
      beat <= 2'h0;
      dly <= GAP;
    end else if (dly != 4'h0) begin
      dly <= dly - 4'h1;
    end else begin
      BURST_READY_N <= 1'b0;
      dly <= GAP;
      beat <= beat + 2'h1;
      if (wr) mem[idx] <= DATA_OUT;
      else DATA_IN <= mem[idx];
      if (!BURST_LAST_N || beat == 2'h3) begin
        busy <= 1'b0;
        writes <= writes + {7'h00, wr};
      end
    end
  end
endmodule // wbc_mem_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
// ************************************************
// cache controller bench
// ************************************************
module testbench;
  reg clk = 0, rst_n = 0, req = 0, wr = 0, page_write_through = 0, hold = 0, external_address_strobe_n = 1, invalidate_qualifier = 0, wbs = 1;
  reg flush = 0, address_hold = 0, bus_backoff_n = 1;
  reg [31:0] addr = 0, wdat = 0, ain = 0, rd;
  wire ack, bus_hold_acknowledge, hit_modified_n, as_n, wrd, bl_n, burst_ready_n, aoe, doe;
  wire [31:0] rdat, aout, din, dout;
  wire [7:0] writes;
  integer failures = 0, comparisons = 0, w0;
  always #5 clk = ~clk;
  wbc_cache_ctrl wbc_cache_ctrl_inst (.CORE_CLK(clk), .RESET_N(rst_n), .CPU_REQ(req),
    .CPU_WR(wr), .CPU_ADDR(addr), .CPU_WDATA(wdat), .PAGE_WRITE_THROUGH(page_write_through), .FLUSH(flush),
    .CPU_ACK(ack), .CPU_RDATA(rdat), .ADDR_IN(ain), .ADDR_OUT(aout), .ADDR_OE(aoe),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .ADDRESS_STROBE_N(as_n),
    .WRITE_READ(wrd), .BURST_LAST_N(bl_n), .BURST_READY_N(burst_ready_n), .WRITEBACK_SELECT(wbs),
    .HOLD(hold), .BUS_HOLD_ACKNOWLEDGE(bus_hold_acknowledge), .BUS_BACKOFF_N(bus_backoff_n), .ADDRESS_HOLD(address_hold),
    .EXTERNAL_ADDRESS_STROBE_N(external_address_strobe_n), .INVALIDATE_QUALIFIER(invalidate_qualifier), .HIT_MODIFIED_N(hit_modified_n));
  wbc_mem_model wbc_mem_model_inst (.CORE_CLK(clk), .RESET_N(rst_n), .ADDRESS_STROBE_N(as_n),
    .WRITE_READ(wrd), .BURST_LAST_N(bl_n), .ADDR_OUT(aout), .DATA_OUT(dout),
    .BURST_READY_N(burst_ready_n), .DATA_IN(din), .writes(writes));
  task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task cpu(input w, input [31:0] a, input [31:0] d);
    integer n;
    begin
      wr <= w; addr <= a; wdat <= d; req <= 1;
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1 && n < 400) begin @(posedge clk); n = n + 1; end
      rd = rdat;
      req <= 0;
      @(posedge clk);
      check("ack", {31'h0, ack === 1'b1 || n < 400}, 32'h1);
    end
  endtask
  task wait_wr(input integer exp);
    integer n;
    begin
      for (n = 0; n < 300 && writes != exp; n = n + 1) @(posedge clk);
      check("writes", {24'h0, writes}, exp);
    end
  endtask
  task snoop(input [31:0] a, input i, input hit, input [1:0] how);
    integer n;
    begin
      if (how == 2'h0) hold <= 1;
      if (how == 2'h1) address_hold <= 1;
      if (how == 2'h2) bus_backoff_n <= 0;
      for (n = 0; n < 100 && how == 2'h0 && bus_hold_acknowledge !== 1'b1; n = n + 1) @(posedge clk);
      @(posedge clk);
      ain <= a; invalidate_qualifier <= i; external_address_strobe_n <= 0;
      @(posedge clk);
      external_address_strobe_n <= 1;
      for (n = 0; n < 8 && hit_modified_n !== 1'b0; n = n + 1) @(posedge clk);
      check("hit_modified", {31'h0, hit_modified_n}, {31'h0, !hit});
      @(posedge clk);
      hold <= 0;
      address_hold <= 0;
      bus_backoff_n <= 1;
      for (n = 0; n < 300 && hit_modified_n !== 1'b1; n = n + 1) @(posedge clk);
      @(posedge clk);
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures = failures + 1;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    cpu(0, 32'h0000_0044, 0);
    check("fill", rd, 32'hcafe_0011);
    w0 = writes;
    cpu(1, 32'h0000_0044, 32'h1234_5678);
    cpu(1, 32'h0000_0048, 32'h9abc_def0);
    cpu(0, 32'h0000_0044, 0);
    check("rd", rd, 32'h1234_5678);
    wait_wr(w0);
    snoop(32'h0000_0040, 0, 1, 2'h0);
    wait_wr(w0 + 1);
    check("mem", wbc_mem_model_inst.mem[17], 32'h1234_5678);
    check("mem", wbc_mem_model_inst.mem[18], 32'h9abc_def0);
    snoop(32'h0000_0040, 1, 0, 2'h0);
    snoop(32'h0000_0040, 0, 0, 2'h0);
    page_write_through <= 1;
    cpu(0, 32'h0000_0080, 0);
    page_write_through <= 0;
    cpu(1, 32'h0000_0080, 32'h0000_1111);
    wait_wr(w0 + 2);
    cpu(1, 32'h0000_0084, 32'h0000_2222);
    wait_wr(w0 + 3);
    wbs <= 0;
    cpu(0, 32'h0000_00c0, 0);
    wbs <= 1;
    cpu(1, 32'h0000_00c0, 32'h0000_3333);
    wait_wr(w0 + 4);
    cpu(0, 32'h0000_0100, 0);
    cpu(1, 32'h0000_0100, 32'h0000_4444);
    cpu(0, 32'h0000_0200, 0);
    check("fill", rd, 32'hcafe_0080);
    wait_wr(w0 + 5);
    check("mem", wbc_mem_model_inst.mem[64], 32'h0000_4444);
    check("mem", wbc_mem_model_inst.mem[65], 32'hcafe_0041);
    flush <= 1;
    @(posedge clk);
    flush <= 0;
    cpu(1, 32'h0000_0200, 32'h0000_5555);
    wait_wr(w0 + 6);
    check("mem", wbc_mem_model_inst.mem[128], 32'h0000_5555);
    cpu(0, 32'h0000_0200, 0);
    check("fill", rd, 32'h0000_5555);
    cpu(1, 32'h0000_0204, 32'h0000_6666);
    snoop(32'h0000_0200, 1, 1, 2'h1);
    wait_wr(w0 + 7);
    check("mem", wbc_mem_model_inst.mem[129], 32'h0000_6666);
    snoop(32'h0000_0200, 0, 0, 2'h2);
    final_report;
  end
endmodule // testbench
bind wbc_cache_ctrl wbc_checker wbc_checker_inst (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
  .EXTERNAL_ADDRESS_STROBE_N(EXTERNAL_ADDRESS_STROBE_N), .HIT_MODIFIED_N(HIT_MODIFIED_N),
  .ADDRESS_STROBE_N(ADDRESS_STROBE_N), .WRITE_READ(WRITE_READ), .ADDR_OUT(ADDR_OUT),
  .ADDR_OE(ADDR_OE), .DATA_OE(DATA_OE), .CPU_ACK(CPU_ACK),
  .BUS_HOLD_ACKNOWLEDGE(BUS_HOLD_ACKNOWLEDGE));
